// >>> src/bca_checker.sv
`timescale 1ns/1ps
module bca_checker #(
    parameter int ID_W = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Command from the initiator logic
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_opcode,
    input  wire logic [ID_W-1:0]   cmd_init_id,
    input  wire logic [31:0]       cmd_lba,
    input  wire logic              cmd_start,
    input  wire logic              cmd_loej,
    input  wire logic [3:0]        cmd_pwr,
    input  wire logic [1:0]        cmd_prevent,
    input  wire logic [1:0]        cmd_page_ctl,
    input  wire logic [31:0]       cmd_param,
    // Answer
    output logic                   rsp_valid,
    output logic [7:0]             rsp_status,
    output logic [3:0]             rsp_sense_key,
    output logic [7:0]             rsp_asc,
    output logic [7:0]             rsp_ascq,
    output logic [31:0]            rsp_data,
    output logic                   irq
);
    // ****************************************
    // State
    // ****************************************
    logic [1:0]             ctrl_ff;        // Removable, length changeable
    logic [31:0]            blk_count_ff;   // Current block count
    logic [31:0]            def_count_ff;   // Default block count
    logic [31:0]            blk_len_ff;     // Block length
    bca_pkg::bca_kind_e     kind_ff;        // Reservation kind
    logic [ID_W-1:0]        holder_ff;      // Holding initiator
    logic [(1<<ID_W)-1:0]   regs_ff;        // Registrant bitmap
    logic [1:0]             prevent_ff;     // Removal lock state
    logic                   sleep_ff;       // Sleep power state
    logic                   medium_ff;      // Medium mounted
    logic [2:0]             int_stat_ff;    // Sticky events
    logic [2:0]             int_mask_ff;    // Event enables
    logic [31:0]            prdata_ff;
    logic                   pready_ff;
    logic                   pslverr_ff;
    logic                   rsp_valid_ff;
    logic [7:0]             rsp_status_ff;
    logic [3:0]             rsp_sk_ff;
    logic [7:0]             rsp_asc_ff;
    logic [7:0]             rsp_ascq_ff;
    logic [31:0]            rsp_data_ff;
    logic                   irq_ff;

    // ****************************************
    // Reservation decision
    // ****************************************
    // Conflict per command class under a given kind; holder never conflicts
    function automatic logic conflict_f(
        input bca_pkg::bca_kind_e kind,
        input logic               holder,
        input logic               registered,
        input logic [7:0]         op,
        input logic               ssu_restricted
    );
        logic wr_class;
        logic rd_class;
        logic ro_kind;
        wr_class = (op == bca_pkg::OP_FORMAT) || (op == bca_pkg::OP_WRITE) ||
                   ((op == bca_pkg::OP_SSU) && ssu_restricted);
        rd_class = (op == bca_pkg::OP_READ) || (op == bca_pkg::OP_VERIFY);
        ro_kind  = (kind == bca_pkg::RK_WE_RO) || (kind == bca_pkg::RK_EA_RO);
        if (kind == bca_pkg::RK_NONE || holder)
            conflict_f = 1'b0;
        else if (ro_kind && registered)
            conflict_f = 1'b0;
        else if (wr_class)
            conflict_f = 1'b1;
        else if (rd_class)
            conflict_f = !(kind == bca_pkg::RK_WE || kind == bca_pkg::RK_WE_RO);
        else
            conflict_f = 1'b0;
    endfunction

    wire        is_ssu      = cmd_opcode == bca_pkg::OP_SSU;
    wire        ssu_restr   = cmd_start || (cmd_pwr != 4'h0);
    wire        is_holder   = (kind_ff != bca_pkg::RK_NONE) && !((kind_ff == bca_pkg::RK_WE_RO) ||
                              (kind_ff == bca_pkg::RK_EA_RO)) && (holder_ff == cmd_init_id);
    wire        is_reg      = regs_ff[cmd_init_id];
    // Combinational on the current reservation registers, so a reservation write acts from the next cycle
    wire        conflict    = conflict_f(kind_ff, is_holder, is_reg, cmd_opcode,
                                         ssu_restr);
    wire        lba_cmd     = (cmd_opcode == bca_pkg::OP_READ) ||
                              (cmd_opcode == bca_pkg::OP_WRITE) ||
                              (cmd_opcode == bca_pkg::OP_VERIFY);
    wire        lba_bad     = lba_cmd && (cmd_lba >= blk_count_ff);
    wire        removable   = ctrl_ff[bca_pkg::CTRL_REMOVABLE_BIT];
    wire        sleep_req   = is_ssu && (cmd_pwr == bca_pkg::PWR_SLEEP);
    wire        sleep_bad   = sleep_req && removable && prevent_ff[0];
    wire        eject_req   = is_ssu && cmd_loej && !cmd_start && (cmd_pwr == 4'h0);
    wire        eject_bad   = eject_req && removable && prevent_ff[0];
    wire        msel_bad    = (cmd_opcode == bca_pkg::OP_MSEL) &&
                              !ctrl_ff[bca_pkg::CTRL_LEN_CHG_BIT];
    wire        take        = ce && cmd_valid;

    // ****************************************
    // Answer selection
    // ****************************************
    logic [7:0]  nxt_status;
    logic [3:0]  nxt_sk;
    logic [7:0]  nxt_asc;
    logic [7:0]  nxt_ascq;
    logic [31:0] nxt_data;
    logic        ok;

    // Conflict ranks first: a refused command alters no lock, power or configuration state
    always_comb
    begin
        nxt_status = bca_pkg::ST_GOOD;
        nxt_sk     = bca_pkg::SK_NONE;
        nxt_asc    = 8'h00;
        nxt_ascq   = 8'h00;
        nxt_data   = 32'h0000_0000;
        ok         = 1'b0;
        if (conflict)
        begin
            nxt_status = bca_pkg::ST_CONFLICT;
        end
        else if (lba_bad)
        begin
            nxt_status = bca_pkg::ST_CHECK;
            nxt_sk     = bca_pkg::SK_ILLEGAL;
            nxt_asc    = bca_pkg::ASC_LBA;
            nxt_ascq   = bca_pkg::ASCQ_LBA;
        end
        else if (sleep_bad)
        begin
            nxt_status = bca_pkg::ST_CHECK;
            nxt_sk     = bca_pkg::SK_ILLEGAL;
            nxt_asc    = bca_pkg::ASC_PWR;
            nxt_ascq   = bca_pkg::ASCQ_PWR;
        end
        else if (eject_bad)
        begin
            nxt_status = bca_pkg::ST_CHECK;
            nxt_sk     = bca_pkg::SK_ILLEGAL;
            nxt_asc    = bca_pkg::ASC_REMOVAL;
            nxt_ascq   = bca_pkg::ASCQ_REMOVAL;
        end
        else if (msel_bad)
        begin
            nxt_status = bca_pkg::ST_CHECK;
            nxt_sk     = bca_pkg::SK_ILLEGAL;
            nxt_asc    = bca_pkg::ASC_FIELD;
        end
        else
        begin
            ok = 1'b1;
            if (cmd_opcode == bca_pkg::OP_READCAP)
                nxt_data = blk_count_ff - 32'h0000_0001;
            else if (cmd_opcode == bca_pkg::OP_MSENSE)
                nxt_data = (cmd_page_ctl == bca_pkg::PC_DEFAULT) ? def_count_ff :
                           (cmd_page_ctl == bca_pkg::PC_SAVED) ? blk_count_ff :
                           blk_len_ff;
        end
    end

    // ****************************************
    // Medium state updates
    // ****************************************
    wire        do_prevent = take && ok && (cmd_opcode == bca_pkg::OP_PREVENT);
    wire        do_msel    = take && ok && (cmd_opcode == bca_pkg::OP_MSEL);
    wire        do_ssu     = take && ok && is_ssu;

    // Lock takes the prevent field whole; start/stop reads bit 0 of the registered lock from the next cycle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            prevent_ff <= 2'h0;
        else if (do_prevent)
            prevent_ff <= cmd_prevent;
    end

    // Sleep entry, wake on start; eject never wakes the spindle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sleep_ff  <= 1'b0;
            medium_ff <= 1'b1;
        end
        else if (do_ssu)
        begin
            if (cmd_pwr == bca_pkg::PWR_SLEEP)
                sleep_ff <= 1'b1;
            else if (cmd_start)
                sleep_ff <= 1'b0;
            if (eject_req)
                medium_ff <= 1'b0;
            else if (cmd_start)
                medium_ff <= 1'b1;
        end
    end

    // ****************************************
    // APB decode
    // ****************************************
    wire        setup   = psel && !penable;
    wire        wr_acc  = ce && psel && penable && pready_ff && pwrite;
    wire        mapped  = (paddr <= bca_pkg::OFS_INT_MASK) && (paddr[1:0] == 2'h0);
    wire [31:0] state_w = {28'h0, medium_ff, sleep_ff, prevent_ff};
    logic [31:0] rd_mux;

    // Read data for the word at paddr
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            bca_pkg::OFS_CTRL:      rd_mux = {30'h0, ctrl_ff};
            bca_pkg::OFS_BLK_COUNT: rd_mux = blk_count_ff;
            bca_pkg::OFS_DEF_COUNT: rd_mux = def_count_ff;
            bca_pkg::OFS_BLK_LEN:   rd_mux = blk_len_ff;
            bca_pkg::OFS_RESV:      rd_mux = {{(24-ID_W){1'b0}}, holder_ff, 5'h0, kind_ff};
            bca_pkg::OFS_REGISTRNT: rd_mux = 32'(regs_ff);
            bca_pkg::OFS_STATE:     rd_mux = state_w;
            bca_pkg::OFS_INT_STAT:  rd_mux = {29'h0, int_stat_ff};
            bca_pkg::OFS_INT_MASK:  rd_mux = {29'h0, int_mask_ff};
            default:                rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait-free access phase: answer is prepared in setup
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped;
            prdata_ff  <= setup ? rd_mux : 32'h0000_0000;
        end
    end

    // Software-owned configuration; mode select may rewrite the length
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_ff      <= bca_pkg::RST_CTRL;
            blk_count_ff <= bca_pkg::RST_COUNT;
            def_count_ff <= bca_pkg::RST_COUNT;
            blk_len_ff   <= bca_pkg::RST_BLK_LEN;
            kind_ff      <= bca_pkg::RK_NONE;
            holder_ff    <= '0;
            regs_ff      <= '0;
            int_mask_ff  <= 3'h0;
        end
        else
        begin
            if (do_msel)
                blk_len_ff <= cmd_param;
            else if (wr_acc && paddr == bca_pkg::OFS_BLK_LEN)
                blk_len_ff <= pwdata;
            if (wr_acc)
            begin
                unique case (paddr)
                    bca_pkg::OFS_CTRL:      ctrl_ff <= pwdata[1:0];
                    bca_pkg::OFS_BLK_COUNT: blk_count_ff <= pwdata;
                    bca_pkg::OFS_DEF_COUNT: def_count_ff <= pwdata;
                    bca_pkg::OFS_RESV:
                    begin
                        kind_ff   <= bca_pkg::bca_kind_e'(pwdata[2:0]);
                        holder_ff <= pwdata[bca_pkg::RESV_HOLDER_LSB +: ID_W];
                    end
                    bca_pkg::OFS_REGISTRNT: regs_ff <= pwdata[(1<<ID_W)-1:0];
                    bca_pkg::OFS_INT_MASK:  int_mask_ff <= pwdata[2:0];
                    default:                ctrl_ff <= ctrl_ff;
                endcase
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    wire [2:0] ev_set = {take && conflict,
                         take && (nxt_status == bca_pkg::ST_CHECK),
                         take};
    wire [2:0] ev_clr = (wr_acc && paddr == bca_pkg::OFS_INT_STAT) ? pwdata[2:0] : 3'h0;
    wire [2:0] nxt_int_stat = (int_stat_ff & ~ev_clr) | ev_set;

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_stat_ff <= 3'h0;
            irq_ff      <= 1'b0;
        end
        else if (ce)
        begin
            int_stat_ff <= nxt_int_stat;
            irq_ff      <= |(nxt_int_stat & int_mask_ff);
        end
    end

    // ****************************************
    // Answer registers
    // ****************************************
    // Answer one cycle after the command, valid for one cycle, fields held until the next
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_valid_ff  <= 1'b0;
            rsp_status_ff <= 8'h00;
            rsp_sk_ff     <= 4'h0;
            rsp_asc_ff    <= 8'h00;
            rsp_ascq_ff   <= 8'h00;
            rsp_data_ff   <= 32'h0000_0000;
        end
        else if (ce)
        begin
            rsp_valid_ff <= cmd_valid;
            if (cmd_valid)
            begin
                rsp_status_ff <= nxt_status;
                rsp_sk_ff     <= nxt_sk;
                rsp_asc_ff    <= nxt_asc;
                rsp_ascq_ff   <= nxt_ascq;
                rsp_data_ff   <= nxt_data;
            end
        end
    end

    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign rsp_valid     = rsp_valid_ff;
    assign rsp_status    = rsp_status_ff;
    assign rsp_sense_key = rsp_sk_ff;
    assign rsp_asc       = rsp_asc_ff;
    assign rsp_ascq      = rsp_ascq_ff;
    assign rsp_data      = rsp_data_ff;
    assign irq           = irq_ff;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_sleep_locked;
        take && sleep_req && removable && prevent_ff[0] && !conflict && !lba_bad;
    endsequence

    a_sleep_reject: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_sleep_locked |=> rsp_valid && rsp_asc == 8'h2c && rsp_ascq == 8'h05)
        else $error("sleep under lock not rejected");

    a_sleep_accept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && sleep_req && !prevent_ff[0] && !conflict |=> sleep_ff && rsp_status == 8'h00)
        else $error("permitted sleep not taken");

    a_lba_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && lba_cmd && !conflict && cmd_lba >= blk_count_ff
        |=> rsp_status == 8'h02 && rsp_asc == 8'h21 && rsp_sense_key == 4'h5)
        else $error("out of range address accepted");

    a_cap_last: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && cmd_opcode == bca_pkg::OP_READCAP |=> rsp_data == $past(blk_count_ff) - 1)
        else $error("capacity not last address");

    a_conflict_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && conflict |=> rsp_status == 8'h18 && int_stat_ff[2])
        else $error("conflict not reported");

    a_stop_allowed: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && (cmd_opcode == bca_pkg::OP_READCAP || (is_ssu && !ssu_restr))
        |=> rsp_status != 8'h18)
        else $error("always-allowed command conflicted");

    a_holder_ok: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && is_holder |=> rsp_status != 8'h18)
        else $error("holder got conflict");

    a_lock_update: assert property (@(posedge clk_sys) disable iff (!rst_b)
        do_prevent |=> prevent_ff == $past(cmd_prevent))
        else $error("removal lock not updated");

    a_eject_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && eject_bad |=> medium_ff == $past(medium_ff) && rsp_status == 8'h02)
        else $error("locked eject performed");

    a_mode_default: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && ok && cmd_opcode == bca_pkg::OP_MSENSE && cmd_page_ctl == 2'h2
        |=> rsp_data == $past(def_count_ff))
        else $error("default count not returned");
endmodule

// >>> src/bca_pkg.sv
// Behaviour
// - Sleep request on a removable medium accepted only in lock 00b/10b
// - Sleep under lock 01b/11b gives 2Ch/05h if removable
// - Eject in sleep without spin-up, lock honoured
// - Blocks zero to n-1; capacity reports n-1
// - Out-of-range block address gives 21h/00h
// - Block length reported; changed by mode select only if changeable
// - Default count on default page, current on saved
// - Conflicting command from non-holder gets conflict status
// - Allowed command from non-holder completes normally
// - Reservation holder commands always complete normally; under RO kinds the code ignores the holder and checks registration only
// - Non-writing command checked once before becoming current
// - Writing command checked before altering the medium
// - Plain stop and capacity query always allowed
// - Start or power change conflicts except registered RO
// - Format/write conflict; read/verify allowed under WE
// - RO registrants allowed all; EA non-holders conflict
// - Eject refused while removal lock forbids it
package bca_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_BLK_COUNT = 8'h04;
    localparam logic [7:0] OFS_DEF_COUNT = 8'h08;
    localparam logic [7:0] OFS_BLK_LEN   = 8'h0c;
    localparam logic [7:0] OFS_RESV      = 8'h10;
    localparam logic [7:0] OFS_REGISTRNT = 8'h14;
    localparam logic [7:0] OFS_STATE     = 8'h18;
    localparam logic [7:0] OFS_INT_STAT  = 8'h1c;
    localparam logic [7:0] OFS_INT_MASK  = 8'h20;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int         CTRL_REMOVABLE_BIT = 0;
    localparam int         CTRL_LEN_CHG_BIT   = 1;
    localparam int         RESV_HOLDER_LSB    = 8;
    localparam logic [1:0] RST_CTRL           = 2'h1;
    localparam logic [31:0] RST_BLK_LEN       = 32'h0000_0200;
    localparam logic [31:0] RST_COUNT         = 32'h0000_1000;
    localparam int         INT_DONE_BIT = 0;
    localparam int         INT_CHECK_BIT = 1;
    localparam int         INT_CONFL_BIT = 2;
    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OP_FORMAT   = 8'h04;
    localparam logic [7:0] OP_MSEL     = 8'h15;
    localparam logic [7:0] OP_MSENSE   = 8'h1a;
    localparam logic [7:0] OP_SSU      = 8'h1b;
    localparam logic [7:0] OP_PREVENT  = 8'h1e;
    localparam logic [7:0] OP_READCAP  = 8'h25;
    localparam logic [7:0] OP_READ     = 8'h28;
    localparam logic [7:0] OP_WRITE    = 8'h2a;
    localparam logic [7:0] OP_VERIFY   = 8'h2f;
    // ****************************************
    // Status, sense and power codes
    // ****************************************
    localparam logic [7:0] ST_GOOD     = 8'h00;
    localparam logic [7:0] ST_CHECK    = 8'h02;
    localparam logic [7:0] ST_CONFLICT = 8'h18;
    localparam logic [3:0] SK_NONE     = 4'h0;
    localparam logic [3:0] SK_ILLEGAL  = 4'h5;
    localparam logic [7:0] ASC_PWR     = 8'h2c;
    localparam logic [7:0] ASCQ_PWR    = 8'h05;
    localparam logic [7:0] ASC_LBA     = 8'h21;
    localparam logic [7:0] ASCQ_LBA    = 8'h00;
    localparam logic [7:0] ASC_FIELD   = 8'h24;
    localparam logic [7:0] ASC_REMOVAL = 8'h53;
    localparam logic [7:0] ASCQ_REMOVAL = 8'h02;
    localparam logic [3:0] PWR_SLEEP   = 4'h5;
    localparam logic [1:0] PC_DEFAULT  = 2'h2;
    localparam logic [1:0] PC_SAVED    = 2'h3;
    // Reservation kinds held by software
    typedef enum logic [2:0] {
        RK_NONE  = 3'b000,
        RK_RR    = 3'b001,
        RK_WE    = 3'b010,
        RK_EA    = 3'b011,
        RK_WE_RO = 3'b100,
        RK_EA_RO = 3'b101
    } bca_kind_e;
endpackage

// >>> testbench/bca_host.sv
`timescale 1ns/1ps
// Initiator model: one command per call, lba and param scrambled once released
module bca_host (
    input  wire logic  clk_sys,
    output logic       cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [3:0] cmd_init_id,
    output logic [31:0] cmd_lba,
    output logic       cmd_start,
    output logic       cmd_loej,
    output logic [3:0] cmd_pwr,
    output logic [1:0] cmd_prevent,
    output logic [1:0] cmd_page_ctl,
    output logic [31:0] cmd_param
);
    initial
    begin
        {cmd_valid, cmd_opcode, cmd_init_id, cmd_lba, cmd_param} = '0;
        {cmd_start, cmd_loej, cmd_pwr, cmd_prevent, cmd_page_ctl} = '0;
    end
    // Flags pack start, eject, lock or page control, power condition
    task automatic send(input logic [7:0] op, input logic [3:0] id, input logic [31:0] lba,
                        input logic [7:0] fl);
        @(posedge clk_sys);
        {cmd_valid, cmd_opcode, cmd_init_id, cmd_lba, cmd_param} <= {1'b1, op, id, lba, lba};
        {cmd_start, cmd_loej, cmd_prevent, cmd_pwr} <= fl;
        cmd_page_ctl <= fl[5:4];
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        // Released fields must not look valid
        {cmd_lba, cmd_param} <= {~lba, ~lba};
        #1;
    endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module testbench;
    logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rsp_data;
    logic pready, pslverr, rsp_valid, irq, cmd_valid, cmd_start, cmd_loej;
    logic [7:0] cmd_opcode, rsp_status, rsp_asc, rsp_ascq;
    logic [3:0] cmd_init_id, cmd_pwr, rsp_sense_key;
    logic [1:0] cmd_prevent, cmd_page_ctl;
    logic [31:0] cmd_lba, cmd_param;
    int n_fail = 0, comparisons = 0, cyc = 0;
    localparam logic [23:0] OK = 24'h0, CF = {bca_pkg::ST_CONFLICT, 16'h0};
    localparam logic [23:0] LBA = {bca_pkg::ST_CHECK, bca_pkg::ASC_LBA, bca_pkg::ASCQ_LBA};
    localparam logic [23:0] PWR = {bca_pkg::ST_CHECK, bca_pkg::ASC_PWR, bca_pkg::ASCQ_PWR};
    localparam logic [23:0] REM = {bca_pkg::ST_CHECK, bca_pkg::ASC_REMOVAL, bca_pkg::ASCQ_REMOVAL};
    localparam logic [23:0] FLD = {bca_pkg::ST_CHECK, bca_pkg::ASC_FIELD, 8'h00};
    always #12.5 clk_sys = ~clk_sys;
    bca_checker uut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_init_id(cmd_init_id), .cmd_lba(cmd_lba), .cmd_start(cmd_start),
        .cmd_loej(cmd_loej), .cmd_pwr(cmd_pwr), .cmd_prevent(cmd_prevent),
        .cmd_page_ctl(cmd_page_ctl), .cmd_param(cmd_param), .rsp_valid(rsp_valid),
        .rsp_status(rsp_status), .rsp_sense_key(rsp_sense_key), .rsp_asc(rsp_asc),
        .rsp_ascq(rsp_ascq), .rsp_data(rsp_data), .irq(irq));
    bca_host host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_init_id(cmd_init_id), .cmd_lba(cmd_lba), .cmd_start(cmd_start),
        .cmd_loej(cmd_loej), .cmd_pwr(cmd_pwr), .cmd_prevent(cmd_prevent),
        .cmd_page_ctl(cmd_page_ctl), .cmd_param(cmd_param));
    // ****************************************
    // Bus and command helpers
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        // Slave answers in its own time; only the cycle ceiling stops this
        do @(posedge clk_sys); while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable, pwdata} <= {2'b00, ~d};
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK("prdata", x, q)
        `CHK("pslverr", xe, e)
    endtask
    task automatic run(input logic [7:0] op, input logic [3:0] id, input logic [31:0] lba,
                       input logic [7:0] fl, input logic [23:0] x);
        host.send(op, id, lba, fl);
        `CHK("rsp_valid", 1'b1, rsp_valid)
        `CHK("status", x[23:16], rsp_status)
        `CHK("sense", (x[23:16] == bca_pkg::ST_CHECK) ? bca_pkg::SK_ILLEGAL : 4'h0, rsp_sense_key)
        `CHK("asc", x[15:0], {rsp_asc, rsp_ascq})
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_cap_mode;
        rd(bca_pkg::OFS_CTRL, 32'h1, 1'b0);
        rd(8'h24, 32'h0, 1'b1);
        run(bca_pkg::OP_READCAP, 4'h0, 32'h0, 8'h00, OK);
        `CHK("capacity", 32'h0fff, rsp_data)
        run(bca_pkg::OP_READ, 4'h0, 32'h0fff, 8'h00, OK);
        run(bca_pkg::OP_WRITE, 4'h0, 32'h1000, 8'h00, LBA);
        wr(bca_pkg::OFS_BLK_COUNT, 32'h10);
        run(bca_pkg::OP_VERIFY, 4'h0, 32'h10, 8'h00, LBA);
        run(bca_pkg::OP_MSENSE, 4'h0, 32'h0, 8'h20, OK);
        `CHK("default count", 32'h1000, rsp_data)
        run(bca_pkg::OP_MSENSE, 4'h0, 32'h0, 8'h30, OK);
        `CHK("saved count", 32'h10, rsp_data)
        run(bca_pkg::OP_MSEL, 4'h0, 32'h400, 8'h00, FLD);
        wr(bca_pkg::OFS_CTRL, 32'h3);
        run(bca_pkg::OP_MSEL, 4'h0, 32'h400, 8'h00, OK);
        rd(bca_pkg::OFS_BLK_LEN, 32'h400, 1'b0);
    endtask
    task automatic t_sleep;
        run(bca_pkg::OP_PREVENT, 4'h0, 32'h0, 8'h10, OK);
        run(bca_pkg::OP_SSU, 4'h0, 32'h0, 8'h05, PWR);
        run(bca_pkg::OP_SSU, 4'h0, 32'h0, 8'h40, REM);
        run(bca_pkg::OP_PREVENT, 4'h0, 32'h0, 8'h30, OK);
        run(bca_pkg::OP_SSU, 4'h0, 32'h0, 8'h05, PWR);
        run(bca_pkg::OP_PREVENT, 4'h0, 32'h0, 8'h20, OK);
        run(bca_pkg::OP_SSU, 4'h0, 32'h0, 8'h05, OK);
        run(bca_pkg::OP_PREVENT, 4'h0, 32'h0, 8'h00, OK);
        run(bca_pkg::OP_SSU, 4'h0, 32'h0, 8'h40, OK);
        rd(bca_pkg::OFS_STATE, 32'h4, 1'b0);
    endtask
    task automatic t_resv;
        wr(bca_pkg::OFS_RESV, 32'h303);
        run(bca_pkg::OP_READ, 4'h2, 32'h0, 8'h00, CF);
        run(bca_pkg::OP_READCAP, 4'h2, 32'h0, 8'h00, OK);
        run(bca_pkg::OP_SSU, 4'h2, 32'h0, 8'h00, OK);
        run(bca_pkg::OP_SSU, 4'h2, 32'h0, 8'h80, CF);
        run(bca_pkg::OP_WRITE, 4'h3, 32'h0, 8'h00, OK);
        wr(bca_pkg::OFS_RESV, 32'h302);
        run(bca_pkg::OP_VERIFY, 4'h2, 32'h0, 8'h00, OK);
        run(bca_pkg::OP_FORMAT, 4'h2, 32'h0, 8'h00, CF);
        wr(bca_pkg::OFS_RESV, 32'h301);
        run(bca_pkg::OP_READ, 4'h2, 32'h0, 8'h00, CF);
        wr(bca_pkg::OFS_RESV, 32'h4);
        wr(bca_pkg::OFS_REGISTRNT, 32'h4);
        run(bca_pkg::OP_SSU, 4'h2, 32'h0, 8'h80, OK);
        run(bca_pkg::OP_WRITE, 4'h4, 32'h0, 8'h00, CF);
        run(bca_pkg::OP_READ, 4'h4, 32'h0, 8'h00, OK);
        wr(bca_pkg::OFS_RESV, 32'h5);
        run(bca_pkg::OP_VERIFY, 4'h4, 32'h0, 8'h00, CF);
        run(bca_pkg::OP_FORMAT, 4'h2, 32'h0, 8'h00, OK);
    endtask
    task automatic t_irq;
        wr(bca_pkg::OFS_INT_MASK, 32'h0);
        wr(bca_pkg::OFS_INT_STAT, 32'h7);
        run(bca_pkg::OP_READ, 4'h2, 32'h20, 8'h00, LBA);
        rd(bca_pkg::OFS_INT_STAT, 32'h3, 1'b0);
        wr(bca_pkg::OFS_INT_MASK, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK("irq raised", 1'b1, irq)
        wr(bca_pkg::OFS_INT_STAT, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK("irq cleared", 1'b0, irq)
    endtask
    task automatic end_sim;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cycle ceiling well above the roughly 130 cycles the scenarios need
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_cap_mode();
        t_sleep();
        t_resv();
        t_irq();
        end_sim();
    end
endmodule
